//--- iebf_gate.sv
`timescale 1ns/1ps
// forwards each source only when flag and enable are both set
module iebf_gate (
	iebf_gate_if.gate g
);
	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_src
			// network source held off on parts without the network module
			if (i == iebf_pkg::BIT_CAN_TX - iebf_pkg::SRC_LSB) begin : g_can
				assign g.request[i] = g.flag[i] & g.enable[i] & g.can_present;
			end else begin : g_other
				assign g.request[i] = g.flag[i] & g.enable[i];
			end
		end
	endgenerate
endmodule

//--- iebf_gate_if.sv
`timescale 1ns/1ps
interface iebf_gate_if;
	logic [5:0] enable;
	logic [5:0] flag;
	logic [5:0] request;
	logic       can_present;
	modport ctl (output enable, output flag, output can_present, input request);
	modport gate (input enable, input flag, input can_present, output request);
endinterface

//--- iebf_pkg.sv
package iebf_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int            ADDR_W          = 4;
	localparam int            DATA_W          = 16;
	localparam int            NUM_SRC         = 6;
	localparam logic [3:0]    ADDR_ENABLE     = 4'h0;  // enable register
	localparam logic [3:0]    ADDR_FLAG       = 4'h1;  // source flags, write one to clear
	localparam logic [3:0]    ADDR_MASK       = 4'h2;  // mask for the interrupt output
	localparam logic [3:0]    ADDR_PENDING    = 4'h3;  // flag and enable, read only
	localparam logic [15:0]   ENABLE_RESET    = 16'h0000;
	localparam logic [15:0]   IMPL_MASK       = 16'h007e;  // bits 6..1
	localparam int            SRC_LSB         = 1;      // first implemented bit
	localparam int            BIT_CAN_TX      = 6;
	localparam int            BIT_DMA_CH7     = 5;
	localparam int            BIT_DMA_CH6     = 4;
	localparam int            BIT_CRC_GEN     = 3;
	localparam int            BIT_UART_B_ERR  = 2;
	localparam int            BIT_UART_A_ERR  = 1;
endpackage

//--- iebf_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - bits 15..7 and bit 0 ignore writes and read zero
// - bit 6 gates the network transmit request, resets to zero
// - bit 5 gates DMA channel 7 transfer complete, resets to zero
// - bit 4 gates DMA channel 6 transfer complete, resets to zero
// - bit 3 gates the CRC generator request, resets to zero
// - bit 2 gates the second UART error request, resets to zero
// - bit 1 gates the first UART error request, resets to zero
// - without the network module its source stays blocked regardless of enable
module iebf_top #(
	parameter bit CAN_PRESENT = 1'b1
) (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	input  wire logic [5:0]  src_event,
	output logic      [15:0] rdata,
	output logic      [5:0]  irq_request,
	output logic             irq
);
	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic [15:0] enable_ff;
	logic [5:0]  flag_ff;
	logic [5:0]  mask_ff;
	logic [15:0] rdata_ff;
	logic [5:0]  req_ff;
	logic        irq_ff;
	logic [5:0]  gated;
	logic [15:0] nxt_enable;
	logic [5:0]  nxt_flag;
	logic [15:0] nxt_rdata;
	// limitations a user must know:
	//   an event that arrives while ce is low is lost, not queued
	//   irq and irq_request are registered from the same gated word
	//   the network source stays off for good when CAN_PRESENT is zero
	// register map, every field sits in bits 6..1 of the word:
	//   offset 0  enable, read/write, clears on reset
	//   offset 1  source flags, write one to clear, an event wins
	//   offset 2  mask for the summary interrupt, read/write
	//   offset 3  pending, flag and enable together, read only
	//   others    read zero, writes ignored
	// bit 6 network transmit request, bit 5 dma channel 7 done,
	// bit 4 dma channel 6 done, bit 3 crc generator,
	// bit 2 second uart error, bit 1 first uart error
	// network source lane held low on parts without the module
	wire [5:0] can_keep = {CAN_PRESENT, 5'h1f};
	// write strobes for each writable register and the clear word for the flags
	wire wr_en   = wr & (addr == iebf_pkg::ADDR_ENABLE);
	wire wr_flag = wr & (addr == iebf_pkg::ADDR_FLAG);
	wire wr_mask = wr & (addr == iebf_pkg::ADDR_MASK);
	wire [5:0] clr = wr_flag ? wdata[6:1] : 6'h00;
	wire [15:0] pend16 = {9'h000, gated, 1'b0};

	// unimplemented bits dropped on write
	assign nxt_enable = wr_en ? (wdata & iebf_pkg::IMPL_MASK) : enable_ff;
	// set beats clear
	assign nxt_flag = (flag_ff & ~clr) | src_event;

	// read mux, unmapped reads zero
	always_comb begin
		case (addr)
			iebf_pkg::ADDR_ENABLE:  nxt_rdata = enable_ff & iebf_pkg::IMPL_MASK;
			iebf_pkg::ADDR_FLAG:    nxt_rdata = {9'h000, flag_ff, 1'b0};
			iebf_pkg::ADDR_MASK:    nxt_rdata = {9'h000, mask_ff, 1'b0};
			iebf_pkg::ADDR_PENDING: nxt_rdata = pend16;
			default:                nxt_rdata = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// gating
	// ------------------------------------------------------------
	// the gate module sees only the six implemented lanes; lane 0 is
	// register bit 1, so every index here is one below the register bit
	iebf_gate_if gi ();
	assign gi.enable      = enable_ff[6:1];
	assign gi.flag        = flag_ff;
	assign gi.can_present = CAN_PRESENT;
	assign gated          = gi.request;
	iebf_gate u_gate (
		.g (gi.gate)
	);

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// enable register, only bits 6..1 can ever hold a one
	always_ff @(posedge clk) begin
		if (srst) begin
			enable_ff <= iebf_pkg::ENABLE_RESET;
		end else if (ce) begin
			enable_ff <= nxt_enable;
		end
	end

	// source flags, an event in the clearing cycle keeps its flag
	always_ff @(posedge clk) begin
		if (srst) begin
			flag_ff <= 6'h00;
		end else if (ce) begin
			flag_ff <= nxt_flag;
		end
	end

	// mask for the summary interrupt output
	always_ff @(posedge clk) begin
		if (srst) begin
			mask_ff <= 6'h00;
		end else if (ce && wr_mask) begin
			mask_ff <= wdata[6:1];
		end
	end

	// read data stands for one cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_ff <= 16'h0000;
		end else if (ce) begin
			rdata_ff <= rd ? nxt_rdata : 16'h0000;
		end
	end

	// forwarded requests and the summary interrupt
	always_ff @(posedge clk) begin
		if (srst) begin
			req_ff <= 6'h00;
			irq_ff <= 1'b0;
		end else if (ce) begin
			req_ff <= gated;
			irq_ff <= |(gated & mask_ff);
		end
	end

	assign rdata       = rdata_ff;
	assign irq_request = req_ff;
	assign irq         = irq_ff;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	unimpl_reads_zero_a: assert property ((enable_ff & ~iebf_pkg::IMPL_MASK) == 16'h0000)
		else $error("unimplemented enable bit set");
	can_enable_write_a: assert property (ce && wr_en |=> enable_ff[6] == $past(wdata[6]))
		else $error("bit 6 write lost");
	dma7_enable_write_a: assert property (ce && wr_en |=> enable_ff[5] == $past(wdata[5]))
		else $error("bit 5 write lost");
	dma6_enable_write_a: assert property (ce && wr_en |=> enable_ff[4] == $past(wdata[4]))
		else $error("bit 4 write lost");
	crc_enable_write_a: assert property (ce && wr_en |=> enable_ff[3] == $past(wdata[3]))
		else $error("bit 3 write lost");
	uartb_enable_write_a: assert property (ce && wr_en |=> enable_ff[2] == $past(wdata[2]))
		else $error("bit 2 write lost");
	uarta_enable_write_a: assert property (ce && wr_en |=> enable_ff[1] == $past(wdata[1]))
		else $error("bit 1 write lost");
	can_absent_block_a: assert property (!CAN_PRESENT |-> !gated[5])
		else $error("network request passed without module");
	request_gating_a: assert property (ce
		|=> req_ff == $past(flag_ff & enable_ff[6:1] & can_keep))
		else $error("forwarded request mismatch");
	read_enable_a: assert property (ce && rd && addr == iebf_pkg::ADDR_ENABLE
		|=> rdata == ($past(enable_ff) & iebf_pkg::IMPL_MASK))
		else $error("enable readback wrong");

	// ------------------------------------------------------------
	// further checks
	// ------------------------------------------------------------
	// reset clears every register and output at the next edge
	reset_clear_a: assert property (disable iff (1'b0)
		srst |=> enable_ff == 16'h0000 && flag_ff == 6'h00 && mask_ff == 6'h00
		&& rdata == 16'h0000 && irq_request == 6'h00 && !irq)
		else $error("reset left state behind");

	// no read strobe, no read data
	read_idle_a: assert property (ce && !rd |=> rdata == 16'h0000)
		else $error("read data without a strobe");

	// unimplemented bits never show on the read port
	rdata_unimpl_a: assert property (rdata[15:7] == 9'h000 && !rdata[0])
		else $error("unimplemented bit read as one");

	// flag word readback
	read_flag_a: assert property (ce && rd && addr == iebf_pkg::ADDR_FLAG
		|=> rdata == {9'h000, $past(flag_ff), 1'b0})
		else $error("flag readback wrong");

	// mask word readback
	read_mask_a: assert property (ce && rd && addr == iebf_pkg::ADDR_MASK
		|=> rdata == {9'h000, $past(mask_ff), 1'b0})
		else $error("mask readback wrong");

	// pending word is flag and enable together
	read_pend_a: assert property (ce && rd && addr == iebf_pkg::ADDR_PENDING
		|=> rdata == {9'h000, $past(flag_ff & enable_ff[6:1] & can_keep), 1'b0})
		else $error("pending readback wrong");

	// unmapped offsets read zero
	read_unmapped_a: assert property (ce && rd && addr > iebf_pkg::ADDR_PENDING
		|=> rdata == 16'h0000)
		else $error("unmapped offset read nonzero");

	// an event with ce high always sets its flag, even against a clear
	flag_set_wins_a: assert property (ce && |src_event
		|=> (flag_ff & $past(src_event)) == $past(src_event))
		else $error("event lost against clear");

	// a one written to a flag clears it when no event arrives
	flag_clear_a: assert property (ce && wr_flag
		|=> (flag_ff & $past(clr & ~src_event)) == 6'h00)
		else $error("flag clear lost");

	// flags never drop without a clear write
	flag_hold_a: assert property (ce && !wr_flag
		|=> (flag_ff & $past(flag_ff)) == $past(flag_ff))
		else $error("flag dropped on its own");

	// mask takes bits 6..1 of the write word
	mask_write_a: assert property (ce && wr_mask |=> mask_ff == $past(wdata[6:1]))
		else $error("mask write lost");

	// mask holds without a write
	mask_hold_a: assert property (ce && !wr_mask |=> mask_ff == $past(mask_ff))
		else $error("mask changed on its own");

	// enable holds without a write
	enable_hold_a: assert property (ce && !wr_en |=> enable_ff == $past(enable_ff))
		else $error("enable changed on its own");

	// pending offset is read only
	pend_ro_a: assert property (ce && wr && addr == iebf_pkg::ADDR_PENDING
		|=> enable_ff == $past(enable_ff) && mask_ff == $past(mask_ff))
		else $error("pending offset took a write");

	// writes to unmapped offsets are ignored
	unmapped_write_a: assert property (ce && wr && addr > iebf_pkg::ADDR_PENDING
		|=> enable_ff == $past(enable_ff) && mask_ff == $past(mask_ff))
		else $error("unmapped offset took a write");

	// a low clock enable freezes every register and output
	freeze_a: assert property (!ce
		|=> $stable(enable_ff) && $stable(flag_ff) && $stable(mask_ff)
		&& $stable(rdata) && $stable(irq_request) && $stable(irq))
		else $error("state moved with clock enable low");

	// summary interrupt follows the masked forwarded requests
	irq_level_a: assert property (ce |=> irq == $past(|(gated & mask_ff)))
		else $error("summary interrupt wrong");

	// the summary interrupt needs an unmasked forwarded request
	irq_needs_mask_a: assert property (ce |=> !irq || |(irq_request & $past(mask_ff)))
		else $error("interrupt without an unmasked request");

	// an all-zero mask keeps the summary interrupt low
	irq_masked_off_a: assert property (ce && mask_ff == 6'h00 |=> !irq)
		else $error("interrupt with empty mask");

	// no masked request, no interrupt
	irq_clear_a: assert property (ce && !(|(gated & mask_ff)) |=> !irq)
		else $error("interrupt without a cause");

	// without the network module its request never leaves
	can_absent_req_a: assert property (!CAN_PRESENT |-> !irq_request[5])
		else $error("network request forwarded without module");

	// unimplemented enable bits stay zero after any write
	for (genvar u = 0; u < 16; u++) begin : g_unimpl
		if (iebf_pkg::IMPL_MASK[u] == 1'b0) begin : g_bit
			unimpl_write_a: assert property (ce && wr_en |=> !enable_ff[u])
				else $error("unimplemented enable bit took a write");
		end
	end

	// per source: enable gates forwarding, flags set and clear per lane
	for (genvar k = 0; k < 6; k++) begin : g_src_chk
		src_blocked_a: assert property (
			ce && !enable_ff[k + 1] |=> !irq_request[k])
			else $error("disabled source forwarded");
		src_passed_a: assert property (
			ce && enable_ff[k + 1] && flag_ff[k] && can_keep[k]
			|=> irq_request[k])
			else $error("enabled source not forwarded");
		flag_lane_set_a: assert property (ce && src_event[k] |=> flag_ff[k])
			else $error("event did not set its flag");
		flag_lane_clr_a: assert property (ce && wr_flag && wdata[k + 1] && !src_event[k]
			|=> !flag_ff[k])
			else $error("flag did not clear");
	end

	// main scenarios the tests should reach
	wr_enable_c: cover property (ce && wr_en && wdata[6:1] == 6'h3f);
	freeze_c:    cover property (!ce ##1 ce);
	irq_rise_c:  cover property (!irq ##1 irq);
	clr_set_c:   cover property (ce && wr_flag && |(wdata[6:1] & src_event));
	read_pend_c: cover property (ce && rd && addr == iebf_pkg::ADDR_PENDING);
endmodule

//--- iebf_top_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module iebf_top_test;
	logic        clk, srst, ce, wr, rd;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata;
	logic [5:0]  src_event, irq_request, req_nc;
	logic        irq;
	int          checked, err_total, cycles;
	// ----------------------------------------
	// design with and without the network source
	// ----------------------------------------
	iebf_top #(.CAN_PRESENT(1'b1)) iebf_top_i (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .src_event(src_event), .rdata(rdata),
		.irq_request(irq_request), .irq(irq));
	iebf_top #(.CAN_PRESENT(1'b0)) iebf_top_nc_i (.clk(clk), .srst(srst), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .src_event(src_event), .rdata(),
		.irq_request(req_nc), .irq());
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one-cycle write strobe
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	// pulse events, then look at the forwarded requests two edges on
	task automatic fire(input logic [5:0] e_req, input logic e_irq);
		@(posedge clk);
		src_event <= 6'h3f;
		@(posedge clk);
		src_event <= 6'h00;
		@(posedge clk);
		#1 `CHK(irq_request, e_req)
		`CHK(req_nc, e_req & 6'h1f)
		`CHK(irq, e_irq)
		wr_reg(iebf_pkg::ADDR_FLAG, 16'h007e);
	endtask
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		addr = 4'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		src_event = 6'h00;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rd_chk(iebf_pkg::ADDR_ENABLE, 16'h0000);
		wr_reg(iebf_pkg::ADDR_ENABLE, 16'hffff);
		rd_chk(iebf_pkg::ADDR_ENABLE, 16'h007e);
		rd_chk(4'h5, 16'h0000);
		$display("register access done");
		wr_reg(iebf_pkg::ADDR_MASK, 16'h007e);
		for (int b = 1; b <= 6; b++) begin
			wr_reg(iebf_pkg::ADDR_ENABLE, 16'h0001 << b);
			fire(6'h01 << (b - 1), 1'b1);
		end
		$display("per-source enable done");
		wr_reg(iebf_pkg::ADDR_ENABLE, 16'h0000);
		fire(6'h00, 1'b0);
		wr_reg(iebf_pkg::ADDR_MASK, 16'h0000);
		wr_reg(iebf_pkg::ADDR_ENABLE, 16'h007e);
		fire(6'h3f, 1'b0);
		$display("blocking and masking done");
		ce <= 1'b0;
		wr_reg(iebf_pkg::ADDR_ENABLE, 16'h0000);
		ce <= 1'b1;
		rd_chk(iebf_pkg::ADDR_ENABLE, 16'h007e);
		$display("clock enable done");
		print_verdict();
	end
endmodule
